// *** evg_regs.svh ***
`ifndef EVG_REGS_SVH
`define EVG_REGS_SVH

// byte offsets of the register regions and single registers
`define EVG_OFS_TRIG      12'h000
`define EVG_OFS_SUB       12'h080
`define EVG_OFS_FLAG      12'h100
`define EVG_OFS_PUB       12'h180
`define EVG_OFS_EN        12'h300
`define EVG_OFS_EN_SET    12'h304
`define EVG_OFS_EN_CLR    12'h308
`define EVG_OFS_SUMMARY   12'h310

// field positions of the subscribe and publish words
`define EVG_CHANNEL_INDEX_LSB     0
`define EVG_CHANNEL_INDEX_MSB     7
`define EVG_LINK_EN_BIT   31
// single bit of task and flag words
`define EVG_BIT0          0

// reset values
`define EVG_RST_LINK      32'h00000000
`define EVG_RST_EN        32'h00000000
`define EVG_RST_FLAG      1'h0

// cycles from a set flag to the interrupt pin
`define EVG_IRQ_LATENCY   1

`endif

// *** evg_pkg.sv ***
package evg_pkg;

  // one bit per event channel of the fabric
  typedef logic [255:0] evg_chan_vec_t;

  // index of an event channel
  typedef logic [7:0] evg_chan_idx_t;

  // one register word of the bus
  typedef logic [31:0] evg_word_t;

endpackage

// *** evg_event_generator.sv ***
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "evg_regs.svh"

module evg_event_generator #(
  parameter int NTASK = 16
) (
  input  wire logic                 clock_i,
  input  wire logic                 reset_i,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  output logic [31:0]               hrdata_o,
  input  wire evg_pkg::evg_chan_vec_t chan_active_i,
  output evg_pkg::evg_chan_vec_t    chan_publish_o,
  output logic                      irq_o
);
  import evg_pkg::*;

  // register map at a glance, all offsets are byte addresses of whole words:
  //   trigger words       0x000 + 4n, write one to fire task n, read zero
  //   subscribe words     0x080 + 4n, enable bit 31, channel index 7:0
  //   event flags         0x100 + 4n, bit 0, read-write
  //   publish words       0x180 + 4n, same layout as subscribe
  //   enable, set, clear  0x300, 0x304, 0x308, one bit per flag
  //   event summary       0x310, read returns all flags and clears all but those firing in that cycle
  // only address bits 11:2 are decoded, so the map repeats every 4 kbyte;
  // hsize is ignored because every register is one aligned word
  // limitations a user must know:
  //   a publish channel that no subscriber listens to simply goes unheard
  //   a summary read clears every flag it reports except those whose task fires in that cycle, so two readers race
  //   hardware and software triggers of one task in one cycle give one event
  //   a flag cleared while its task fires stays set; no event is lost
  // the block has a single clock; the fabric and the bus share it

  // region bases and field positions, sized to the decoded address bits
  localparam logic [11:0] O_TRIG = `EVG_OFS_TRIG;
  localparam logic [11:0] O_SUB  = `EVG_OFS_SUB;
  localparam logic [11:0] O_FLAG = `EVG_OFS_FLAG;
  localparam logic [11:0] O_PUB  = `EVG_OFS_PUB;
  localparam logic [11:0] O_EN   = `EVG_OFS_EN;
  localparam logic [11:0] O_ESET = `EVG_OFS_EN_SET;
  localparam logic [11:0] O_ECLR = `EVG_OFS_EN_CLR;
  localparam logic [11:0] O_SUM  = `EVG_OFS_SUMMARY;
  localparam int          LEN    = `EVG_LINK_EN_BIT;
  localparam int          CL     = `EVG_CHANNEL_INDEX_LSB;
  localparam int          CM     = `EVG_CHANNEL_INDEX_MSB;
  localparam int          B0     = `EVG_BIT0;

  // bus address/data phase state
  logic                 dp_valid_q;
  logic                 dp_valid_d;
  logic                 dp_write_q;
  logic                 dp_write_d;
  logic [9:0]           dp_word_q;
  logic [9:0]           dp_word_d;
  evg_word_t            rdata_q;
  evg_word_t            rdata_d;

  // configuration and event state
  logic [NTASK-1:0]     sub_en_q;
  logic [NTASK-1:0]     sub_en_d;
  evg_chan_idx_t        sub_idx_q [NTASK];
  evg_chan_idx_t        sub_idx_d [NTASK];
  logic [NTASK-1:0]     pub_en_q;
  logic [NTASK-1:0]     pub_en_d;
  evg_chan_idx_t        pub_idx_q [NTASK];
  evg_chan_idx_t        pub_idx_d [NTASK];
  logic [NTASK-1:0]     flag_q;
  logic [NTASK-1:0]     flag_d;
  logic [NTASK-1:0]     flag_w;
  logic [NTASK-1:0]     en_q;
  logic [NTASK-1:0]     en_d;
  logic                 irq_q;
  logic                 irq_d;
  evg_chan_vec_t        chan_pub_q;
  evg_chan_vec_t        chan_pub_d;

  // decode helpers
  logic                 accept;
  logic                 rd_acc;
  logic                 wr_dp;
  logic [9:0]           rd_word;
  logic [NTASK-1:0]     sw_fire;
  logic [NTASK-1:0]     hw_fire;
  logic [NTASK-1:0]     fire;
  logic [NTASK-1:0]     wr_sub;
  logic [NTASK-1:0]     wr_pub;
  logic [NTASK-1:0]     wr_flag;
  logic [NTASK-1:0]     rd_sub;
  logic [NTASK-1:0]     rd_pub;
  logic [NTASK-1:0]     rd_flag;
  evg_chan_vec_t        pub_hot [NTASK];
  evg_word_t            rd_part [NTASK];
  logic                 rd_sum;

  // flags that may raise the interrupt
  logic [NTASK-1:0]     irq_pending;

  // the slave never stalls: hreadyout is tied high, so an address phase
  // is taken at the first edge with hsel, an active htrans and hready.
  // the data phase of a write is the following cycle, where hwdata stands;
  // all register updates happen at the edge that ends that data phase.
  // read data are gathered in the address phase and registered, so they
  // stand on hrdata for exactly the data phase cycle.
  // a transfer is taken only when the bus is ready and the slot is active
  assign accept  = hsel_i & htrans_i[1] & hready_i;
  assign rd_acc  = accept & ~hwrite_i;
  assign wr_dp   = dp_valid_q & dp_write_q;
  assign rd_word = haddr_i[11:2];
  assign rd_sum  = rd_acc & (rd_word == O_SUM[11:2]);

  // per-task address hits, firing and publish contributions
  genvar gi;
  generate
    for (gi = 0; gi < NTASK; gi++) begin : g_task
      // bit 0 of the data is the only bit a trigger word looks at
      // trigger word write
      assign sw_fire[gi] = wr_dp & (dp_word_q == O_TRIG[11:2] + 10'(gi)) & hwdata_i[B0];
      assign hw_fire[gi] = sub_en_q[gi] & chan_active_i[sub_idx_q[gi]];
      assign fire[gi]    = sw_fire[gi] | hw_fire[gi];
      // address hits of this task's words in the data and address phase
      assign wr_sub[gi]  = wr_dp & (dp_word_q == O_SUB[11:2] + 10'(gi));
      assign wr_pub[gi]  = wr_dp & (dp_word_q == O_PUB[11:2] + 10'(gi));
      assign wr_flag[gi] = wr_dp & (dp_word_q == O_FLAG[11:2] + 10'(gi));
      assign rd_sub[gi]  = rd_acc & (rd_word == O_SUB[11:2] + 10'(gi));
      assign rd_pub[gi]  = rd_acc & (rd_word == O_PUB[11:2] + 10'(gi));
      assign rd_flag[gi] = rd_acc & (rd_word == O_FLAG[11:2] + 10'(gi));
      // one-hot pulse on the chosen channel
      assign pub_hot[gi] = (fire[gi] & pub_en_q[gi]) ?
                           (evg_chan_vec_t'(1) << pub_idx_q[gi]) : '0;
      // read value of this task's words, taken from next-state values
      // so a write in its data phase shows in a read taken in that cycle
      assign rd_part[gi] =
          (rd_sub[gi]  ? (evg_word_t'(sub_en_d[gi]) << LEN) |
                         (evg_word_t'(sub_idx_d[gi]) << CL) : '0) |
          (rd_pub[gi]  ? (evg_word_t'(pub_en_d[gi]) << LEN) |
                         (evg_word_t'(pub_idx_d[gi]) << CL) : '0) |
          (rd_flag[gi] ? evg_word_t'(flag_w[gi]) : '0);
    end
  endgenerate

  // next bus phase; reads are answered from values that already hold
  // a write in its data phase, so back-to-back write/read sees new data
  always_comb begin
    dp_valid_d = accept;
    dp_write_d = hwrite_i;
    dp_word_d  = haddr_i[11:2];
    rdata_d    = '0;
    if (rd_acc) begin
      // words of different tasks never overlap, so an or merges them
      for (int i = 0; i < NTASK; i++) begin
        rdata_d = rdata_d | rd_part[i];
      end
      if (rd_word == O_EN[11:2] || rd_word == O_ESET[11:2] ||
          rd_word == O_ECLR[11:2]) begin
        rdata_d = evg_word_t'(en_d);
      end
      if (rd_sum) begin
        rdata_d = evg_word_t'(flag_w);
      end
    end
  end

  // reset clears the bus phase, so a transfer cut by reset is dropped
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_word_q  <= '0;
      rdata_q    <= '0;
    end else begin
      dp_valid_q <= dp_valid_d;
      dp_write_q <= dp_write_d;
      dp_word_q  <= dp_word_d;
      rdata_q    <= rdata_d;
    end
  end

  // channel indices are eight bits wide, so every index names a channel;
  // an enable bit of zero keeps the stored index but ignores the channel.
  // subscriptions sample the channel vector directly: the fabric runs on
  // this clock, so no synchroniser is needed, and a pulse wider than one
  // cycle fires the task once for every cycle it stands.
  // subscribe and publish words
  always_comb begin
    sub_en_d  = sub_en_q;
    sub_idx_d = sub_idx_q;
    pub_en_d  = pub_en_q;
    pub_idx_d = pub_idx_q;
    for (int i = 0; i < NTASK; i++) begin
      if (wr_sub[i]) begin
        sub_en_d[i]  = hwdata_i[LEN];
        sub_idx_d[i] = hwdata_i[CM:CL];
      end
      if (wr_pub[i]) begin
        pub_en_d[i]  = hwdata_i[LEN];
        pub_idx_d[i] = hwdata_i[CM:CL];
      end
    end
  end

  // configuration registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sub_en_q <= '0;
      pub_en_q <= '0;
      for (int i = 0; i < NTASK; i++) begin
        sub_idx_q[i] <= evg_chan_idx_t'(`EVG_RST_LINK);
        pub_idx_q[i] <= evg_chan_idx_t'(`EVG_RST_LINK);
      end
    end else begin
      sub_en_q  <= sub_en_d;
      sub_idx_q <= sub_idx_d;
      pub_en_q  <= pub_en_d;
      pub_idx_q <= pub_idx_d;
    end
  end

  // a flag is the sticky status of its event. software clears it either
  // by writing zero to its own word or by reading the summary word; a task
  // firing in the same cycle still leaves the flag set.
  // writing one to a flag word sets it too but is not a generation of the
  // event, so it does not publish.
  // event flags: a firing task always wins over a clear in the same cycle
  always_comb begin
    flag_w = flag_q;
    for (int i = 0; i < NTASK; i++) begin
      if (wr_flag[i]) begin
        flag_w[i] = hwdata_i[B0];
      end
    end
    flag_w = flag_w | fire;
    // summary read hands over every flag it reported
    flag_d = rd_sum ? fire : flag_w;
  end

  // flag registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      flag_q <= {NTASK{`EVG_RST_FLAG}};
    end else begin
      flag_q <= flag_d;
    end
  end

  // the three enable views share one register; only one view can be written
  // per data phase, so the order of the tests below never matters.
  // reads of any view return the enables as they will stand after a write
  // in the same cycle, which keeps back-to-back write and read coherent.
  // interrupt enable with set and clear views
  always_comb begin
    en_d = en_q;
    if (wr_dp && dp_word_q == O_EN[11:2]) begin
      en_d = hwdata_i[NTASK-1:0];
    end
    if (wr_dp && dp_word_q == O_ESET[11:2]) begin
      en_d = en_q | hwdata_i[NTASK-1:0];
    end
    if (wr_dp && dp_word_q == O_ECLR[11:2]) begin
      en_d = en_q & ~hwdata_i[NTASK-1:0];
    end
  end

  // enable register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      en_q <= NTASK'(`EVG_RST_EN);
    end else begin
      en_q <= en_d;
    end
  end

  assign irq_pending = flag_q & en_q;

  // the interrupt is a level: it stays high while any enabled flag is set
  // and falls one cycle after the last one is cleared or masked.
  // one register stage gives the single cycle from flag to pin.
  // a publish pulse lasts one cycle per generation; events of several tasks
  // on one channel in one cycle merge into a single pulse, and a channel
  // pulse that fires a subscribed task publishes in the cycle after it.
  // interrupt and channel pulses are registered; costs one cycle
  // but keeps the pins glitch free
  always_comb begin
    irq_d      = |irq_pending;
    chan_pub_d = '0;
    // merged pulses: two events on one channel give one pulse
    for (int i = 0; i < NTASK; i++) begin
      chan_pub_d = chan_pub_d | pub_hot[i];
    end
  end

  // output registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      irq_q      <= 1'b0;
      chan_pub_q <= '0;
    end else begin
      irq_q      <= irq_d;
      chan_pub_q <= chan_pub_d;
    end
  end

  // hresp stays OKAY: unmapped writes are dropped and unmapped reads give
  // zero, so software probing the map sees no bus errors.
  // zero-wait slave, always OKAY; unmapped reads give zero
  assign hreadyout_o    = 1'b1;
  assign hresp_o        = 1'b0;
  assign hrdata_o       = rdata_q;
  assign irq_o          = irq_q;
  assign chan_publish_o = chan_pub_q;

endmodule

// *** evg_event_generator_assertions.sv ***
`timescale 1ns/1ps
module evg_event_generator_assertions #(
  parameter int NTASK = 16
) (
  input wire logic                   clock_i,
  input wire logic                   reset_i,
  input wire logic                   hsel_i,
  input wire logic [31:0]            haddr_i,
  input wire logic [1:0]             htrans_i,
  input wire logic                   hwrite_i,
  input wire logic [2:0]             hsize_i,
  input wire logic [31:0]            hwdata_i,
  input wire logic                   hready_i,
  input wire logic                   hreadyout_o,
  input wire logic                   hresp_o,
  input wire logic [31:0]            hrdata_o,
  input wire evg_pkg::evg_chan_vec_t chan_active_i,
  input wire evg_pkg::evg_chan_vec_t chan_publish_o,
  input wire logic                   irq_o
);
  import evg_pkg::*;
  // data phase shadow and enable mirror, so read data can be judged at the pins
  logic        act_q, act_d, wr_q, wr_d, wdp, rdp, fire;
  logic [11:0] adr_q, adr_d;
  logic [15:0] en_q, en_d;
  assign wdp  = act_q & wr_q;
  assign rdp  = act_q & ~wr_q;
  assign fire = (wdp && adr_q < 12'(NTASK * 4) && hwdata_i[0]) || chan_active_i != '0;
  // next shadow state
  always_comb begin
    act_d = hsel_i & htrans_i[1] & hready_i;
    wr_d  = hwrite_i;
    adr_d = {haddr_i[11:2], 2'h0};
    en_d  = en_q;
    if (wdp && adr_q == 12'h300) en_d = hwdata_i[15:0];
    if (wdp && adr_q == 12'h304) en_d = en_q | hwdata_i[15:0];
    if (wdp && adr_q == 12'h308) en_d = en_q & ~hwdata_i[15:0];
  end
  // shadow registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      act_q <= 1'b0;
      wr_q  <= 1'b0;
      adr_q <= 12'h000;
      en_q  <= 16'h0000;
    end else begin
      act_q <= act_d;
      wr_q  <= wr_d;
      adr_q <= adr_d;
      en_q  <= en_d;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  ready_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus stalled or error response");
  reset_quiet_a: assert property ($fell(reset_i) |-> !irq_o && chan_publish_o == '0)
    else $error("outputs not idle after reset");
  trig_read_a: assert property (rdp && (adr_q < 12'h080 || adr_q[11:10] != 2'h0)
    |-> hrdata_o == '0)
    else $error("write-only or unmapped read not zero");
  flag_read_a: assert property (rdp && adr_q[11:6] == 6'h04 |-> hrdata_o[31:1] == '0)
    else $error("flag read has upper bits");
  en_read_a: assert property (rdp && adr_q inside {12'h300, 12'h304, 12'h308}
    |-> hrdata_o == {16'h0000, en_q})
    else $error("enable read mismatch");
  irq_rise_a: assert property (wdp && adr_q < 12'(NTASK * 4) && hwdata_i[0]
    && en_q[adr_q[5:2]] |=> ##1 irq_o)
    else $error("interrupt missing after enabled trigger");
  irq_gate_a: assert property ($past(en_q) == '0 |-> !irq_o)
    else $error("interrupt with all enables clear");
  pub_cause_a: assert property (chan_publish_o != '0 |-> $past(fire))
    else $error("publish pulse without a fired task");
  cover property (wdp && adr_q < 12'h040 ##2 irq_o);
  cover property (chan_publish_o != '0);
  cover property (chan_active_i != '0);
  cover property (rdp && adr_q == 12'h310 && hrdata_o != '0);
endmodule
bind evg_event_generator evg_event_generator_assertions #(.NTASK(NTASK))
  evg_event_generator_assertions_i (.*);

// *** evg_fabric_model.sv ***
`timescale 1ns/1ps
module evg_fabric_model (
  input  wire logic                   clock_i,
  input  wire evg_pkg::evg_chan_vec_t chan_publish_i,
  output evg_pkg::evg_chan_vec_t      chan_active_o
);
  import evg_pkg::*;
  int hits [256];
  int total;
  // channels idle low between pulses
  initial chan_active_o = '0;
  always @(posedge clock_i) begin
    for (int c = 0; c < 256; c++) begin
      if (chan_publish_i[c] === 1'b1) begin
        hits[c]++;
        total++;
      end
    end
  end
  // one-cycle channel activity; a large dly stands for a slow source
  task automatic pulse(input evg_chan_idx_t ch, input int dly);
    repeat (dly) @(posedge clock_i);
    chan_active_o[ch] <= 1'b1;
    @(posedge clock_i);
    chan_active_o[ch] <= 1'b0;
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import evg_pkg::*;
  typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] r;} evg_row_s;
  logic          clock_i, reset_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o, irq_o;
  logic [31:0]   haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0]    htrans_i;
  logic [2:0]    hsize_i;
  evg_chan_vec_t chan_active_i, chan_publish_o;
  int            n_fail, n_compared;
  logic [31:0]   rst_a [4] = '{32'h080, 32'h100, 32'h180, 32'h300};
  // write value, then expected read back
  evg_row_s rows [10] = '{'{32'h080, 32'h80000005, 32'h80000005},
    '{32'h0bc, 32'hffffffff, 32'h800000ff}, '{32'h1bc, 32'h7fffff12, 32'h00000012},
    '{32'h13c, 32'h1, 32'h1}, '{32'h13c, 32'h0, 32'h0}, '{32'h000, 32'h1, 32'h0},
    '{32'h400, 32'hff, 32'h0}, '{32'h300, 32'hffff5555, 32'h5555},
    '{32'h304, 32'h00a0, 32'h55f5}, '{32'h308, 32'h0005, 32'h55f0}};
  assign hready_i = hreadyout_o;
  evg_event_generator #(.NTASK(16)) evg_event_generator_i (.*);
  evg_fabric_model evg_fabric_model_i (.clock_i(clock_i), .chan_publish_i(chan_publish_o),
    .chan_active_o(chan_active_i));
  // one single transfer; request held until ready is sampled high
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input logic [31:0] a, e);
    xfer(1'b0, a, 32'h0, rd);
    chk("read data", e, rd);
  endtask
  task automatic irqchk(input logic e);
    repeat (2) @(posedge clock_i);
    chk("irq", {31'h0, e}, {31'h0, irq_o});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // the tests need under 400 cycles, so 100 us means a hang
  initial begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    {reset_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    reset_i = 1'b1;
    hsize_i = 3'h2;
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    foreach (rst_a[i]) rdchk(rst_a[i], 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
    end
    $display("table test done");
    wr(32'h308, 32'hffff);
    for (int n = 0; n < 16; n++) wr(32'h100 + 4 * n, 32'h0);
    wr(32'h304, 32'h8);
    wr(32'h014, 32'h1);
    rdchk(32'h114, 32'h1);
    rdchk(32'h110, 32'h0);
    irqchk(1'b0);
    wr(32'h00c, 32'h1);
    @(posedge clock_i);
    chk("irq early", 32'h0, {31'h0, irq_o});
    @(posedge clock_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    wr(32'h308, 32'h8);
    irqchk(1'b0);
    wr(32'h304, 32'h8);
    irqchk(1'b1);
    wr(32'h10c, 32'h0);
    irqchk(1'b0);
    $display("irq test done");
    wr(32'h09c, 32'h80000021);
    wr(32'h19c, 32'h800000c4);
    evg_fabric_model_i.pulse(8'h21, 3);
    rdchk(32'h11c, 32'h1);
    wr(32'h01c, 32'h1);
    wr(32'h018, 32'h1);
    repeat (2) @(posedge clock_i);
    chk("pub hits", 32'd2, evg_fabric_model_i.hits[196]);
    chk("pub total", 32'd2, evg_fabric_model_i.total);
    $display("channel test done");
    // flags 5, 6 and 7 stand here; a summary read hands them over and clears them
    wr(32'h304, 32'h20);
    irqchk(1'b1);
    rdchk(32'h310, 32'h00e0);
    irqchk(1'b0);
    rdchk(32'h310, 32'h0);
    rdchk(32'h11c, 32'h0);
    $display("summary test done");
    // reset in mid-run while a flag raises the interrupt
    wr(32'h014, 32'h1);
    irqchk(1'b1);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    chk("irq after reset", 32'h0, {31'h0, irq_o});
    rdchk(32'h304, 32'h0);
    rdchk(32'h114, 32'h0);
    rdchk(32'h19c, 32'h0);
    $display("mid-run reset test done");
    tally_and_finish;
  end
endmodule
